// ---- fbod_map.svh ----
// constants for the flash bus host controller
//
// Contract
// RL1: read drives chip select and output enable low, write enable high.
// RL2: command write drives write enable and chip select low, output enable high.
// RL3: width-select high gives word mode, all sixteen data pins used.
// RL4: width-select low gives byte mode; top data pin carries lowest address bit.
// RL5: word mode uses address 18..0; byte mode adds the extra low bit.
// RL6: device starts in read-array after power-up and hardware reset.
// RL7: device stays in read-array until a command changes it.
// RL8: command register has no address; latches feed the state machine.
// RL9: bypass mode programs one unit in two writes instead of four.
// RL10: program data is byte or word according to width-select.
// RL11: erase covers one sector, several, or the whole device.
// RL12: identification reads return codes on the low eight data pins.
// RL13: during program or erase, reads return status on low eight pins.
// RL14: chip select and reset both high puts the device in standby.
// RL15: leaving standby, valid data only after full chip-enable access time.
// RL16: deselecting during program or erase does not abort it.
// RL17: protect uses elevated reset, addr bit 6 low, bit 1 high, bit 0 low.
// RL18: unprotect uses elevated reset, addr bit 6 high, bit 1 high, bit 0 low.
// RL19: output enable high floats the device data outputs.
// RL20: reset low aborts operations, floats outputs, ignores cycles.
// RL21: undefined pin combinations act as no operation.
`ifndef FBOD_MAP_SVH
`define FBOD_MAP_SVH
`define FBOD_CLK_MHZ 10
`define FBOD_T_ACC_NS 70
`define FBOD_T_WP_NS 35
`define FBOD_T_RP_NS 500
`define FBOD_T_RH_NS 50
`define FBOD_ACC_CYC ((`FBOD_T_ACC_NS * `FBOD_CLK_MHZ + 999) / 1000)
`define FBOD_WP_CYC ((`FBOD_T_WP_NS * `FBOD_CLK_MHZ + 999) / 1000)
`define FBOD_RP_CYC ((`FBOD_T_RP_NS * `FBOD_CLK_MHZ + 999) / 1000)
`define FBOD_RH_CYC ((`FBOD_T_RH_NS * `FBOD_CLK_MHZ + 999) / 1000)
`define FBOD_PROT_A6_BIT 6
`define FBOD_PROT_A1_BIT 1
`define FBOD_PROT_A0_BIT 0
`endif

// ---- fbod_pkg.sv ----
// types for the flash bus host controller
package fbod_pkg;
    typedef enum logic [2:0] {
        FBOD_OP_READ = 3'h0,
        FBOD_OP_WRITE = 3'h1,
        FBOD_OP_RESET = 3'h2,
        FBOD_OP_PROTECT = 3'h3,
        FBOD_OP_UNPROTECT = 3'h4
    } fbod_op_t;
    typedef enum logic [2:0] {
        FBOD_ST_IDLE = 3'h0,
        FBOD_ST_SETUP = 3'h1,
        FBOD_ST_STROBE = 3'h2,
        FBOD_ST_RECOVER = 3'h3,
        FBOD_ST_RESET = 3'h4
    } fbod_state_t;
endpackage

// ---- fbod_host.sv ----
// host-side bus controller for an asynchronous parallel nor flash
`include "fbod_map.svh"
`timescale 1ns/100ps
`default_nettype none
module fbod_host #(
    parameter int ACC_CYC = `FBOD_ACC_CYC,
    parameter int WP_CYC = `FBOD_WP_CYC,
    parameter int RP_CYC = `FBOD_RP_CYC,
    parameter int RH_CYC = `FBOD_RH_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire fbod_pkg::fbod_op_t req_op,
    input wire logic req_byte_mode,
    input wire logic [19:0] req_addr,
    input wire logic [15:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic [15:0] rsp_rdata,
    output logic dev_busy,
    output logic flash_cs_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic flash_reset_n,
    output logic flash_elevated_id_voltage,
    output logic flash_byte_n,
    output logic [18:0] flash_addr,
    output logic [14:0] flash_dq_out,
    output logic [14:0] flash_dq_oe,
    output logic top_data_or_low_addr_out,
    output logic top_data_or_low_addr_oe,
    input wire logic [14:0] flash_dq_in,
    input wire logic top_data_or_low_addr_in,
    input wire logic ready_busy_out
);
    // ************************************************************
    // pin input synchronisers
    // ************************************************************
    logic [15:0] dq_meta_ff;
    logic [15:0] dq_sync_ff;
    logic [1:0] rb_ff;
    always_ff @(posedge core_clk) begin
        dq_meta_ff <= {top_data_or_low_addr_in, flash_dq_in};
        dq_sync_ff <= dq_meta_ff;
        rb_ff <= {rb_ff[0], ready_busy_out};
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dev_busy <= 1'b0;
        end else begin
            // program or erase keeps running even while deselected [RL16]
            dev_busy <= ~rb_ff[1];
        end
    end

    // ************************************************************
    // sequencer
    // ************************************************************
    fbod_pkg::fbod_state_t state_ff;
    fbod_pkg::fbod_op_t op_ff;
    logic [7:0] cnt_ff;
    logic byte_ff;
    logic [19:0] addr_ff;
    logic [15:0] wdata_ff;
    localparam logic [7:0] ACC_N = 8'(ACC_CYC);
    localparam logic [7:0] WP_N = 8'(WP_CYC);
    localparam logic [7:0] RP_N = 8'(RP_CYC);
    localparam logic [7:0] RH_N = 8'(RH_CYC);
    // two-flop input path lags the pins; stretch reads so the sample lands after access
    localparam logic [7:0] SYNC_N = 8'h02;
    wire logic cnt_done = (cnt_ff <= 8'h01);
    wire logic is_read = (op_ff == fbod_pkg::FBOD_OP_READ);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_ff <= fbod_pkg::FBOD_ST_IDLE;
            op_ff <= fbod_pkg::FBOD_OP_READ;
            cnt_ff <= 8'h00;
            byte_ff <= 1'b0;
            addr_ff <= 20'h00000;
            wdata_ff <= 16'h0000;
        end else begin
            case (state_ff)
                fbod_pkg::FBOD_ST_IDLE: begin
                    if (req_valid) begin
                        op_ff <= req_op;
                        byte_ff <= req_byte_mode;
                        addr_ff <= req_addr;
                        wdata_ff <= req_wdata;
                        // unknown codes fall back to a harmless read [RL21]
                        if (req_op == fbod_pkg::FBOD_OP_RESET) begin
                            state_ff <= fbod_pkg::FBOD_ST_RESET;
                            cnt_ff <= RP_N;
                        end else begin
                            state_ff <= fbod_pkg::FBOD_ST_SETUP;
                            cnt_ff <= 8'h01;
                        end
                        if (req_op > fbod_pkg::FBOD_OP_UNPROTECT) begin
                            op_ff <= fbod_pkg::FBOD_OP_READ;
                        end
                    end
                end
                fbod_pkg::FBOD_ST_SETUP: begin
                    state_ff <= fbod_pkg::FBOD_ST_STROBE;
                    // chip-enable access time also covers standby exit [RL15]
                    cnt_ff <= is_read ? ACC_N + SYNC_N : WP_N;
                end
                fbod_pkg::FBOD_ST_STROBE: begin
                    cnt_ff <= cnt_ff - 8'h01;
                    if (cnt_done) begin
                        state_ff <= fbod_pkg::FBOD_ST_RECOVER;
                        cnt_ff <= 8'h01;
                    end
                end
                fbod_pkg::FBOD_ST_RECOVER: begin
                    // after a hardware reset this also covers the wait before the next read
                    cnt_ff <= cnt_ff - 8'h01;
                    if (cnt_done) begin
                        state_ff <= fbod_pkg::FBOD_ST_IDLE;
                    end
                end
                fbod_pkg::FBOD_ST_RESET: begin
                    cnt_ff <= cnt_ff - 8'h01;
                    if (cnt_done) begin
                        // recovery before next read after reset release [RL20]
                        state_ff <= fbod_pkg::FBOD_ST_RECOVER;
                        cnt_ff <= RH_N;
                    end
                end
                default: begin
                    state_ff <= fbod_pkg::FBOD_ST_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // pin drive
    // ************************************************************
    wire logic in_strobe = (state_ff == fbod_pkg::FBOD_ST_STROBE);
    // writes keep select and data one cycle past the strobe; the latch edge is its rise
    wire logic wr_tail = (state_ff == fbod_pkg::FBOD_ST_RECOVER) & ~is_read &
        (op_ff != fbod_pkg::FBOD_OP_RESET);
    wire logic active = in_strobe | (state_ff == fbod_pkg::FBOD_ST_SETUP) | wr_tail;
    wire logic prot_op = (op_ff == fbod_pkg::FBOD_OP_PROTECT) |
        (op_ff == fbod_pkg::FBOD_OP_UNPROTECT);
    logic [18:0] nxt_addr;
    always_comb begin
        // word mode uses addr 19..1 on a18..a0; byte mode adds bit 0 [RL5]
        nxt_addr = addr_ff[19:1];
        if (prot_op) begin
            nxt_addr[`FBOD_PROT_A6_BIT] = (op_ff == fbod_pkg::FBOD_OP_UNPROTECT); // [RL17] [RL18]
            nxt_addr[`FBOD_PROT_A1_BIT] = 1'b1; // [RL17] [RL18]
            nxt_addr[`FBOD_PROT_A0_BIT] = 1'b0; // [RL17] [RL18]
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            flash_cs_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
            flash_reset_n <= 1'b0;
            flash_elevated_id_voltage <= 1'b0;
            flash_byte_n <= 1'b1;
        end else begin
            // idle: chip select and reset high means standby [RL14]
            flash_cs_n <= ~active; // [RL1] [RL2]
            flash_oe_n <= ~(active & is_read); // [RL1] [RL19]
            flash_we_n <= ~(in_strobe & ~is_read); // [RL2]
            flash_reset_n <= (state_ff != fbod_pkg::FBOD_ST_RESET); // [RL6] [RL20]
            flash_elevated_id_voltage <= active & prot_op; // [RL17] [RL18]
            flash_byte_n <= ~byte_ff; // [RL3] [RL4] [RL10]
        end
    end

    // address and data follow the latched request, one cycle behind state
    always_ff @(posedge core_clk) begin
        if (rst) begin
            flash_addr <= 19'h00000;
            flash_dq_out <= 15'h0000;
            flash_dq_oe <= 15'h0000;
            top_data_or_low_addr_out <= 1'b0;
            top_data_or_low_addr_oe <= 1'b0;
        end else begin
            flash_addr <= nxt_addr; // [RL11] [RL8]
            flash_dq_out <= byte_ff ? {7'h00, wdata_ff[7:0]} : wdata_ff[14:0];
            // drive data only on writes; upper lanes float in byte mode [RL4]
            flash_dq_oe <= (active & ~is_read) ?
                (byte_ff ? 15'h00FF : 15'h7FFF) : 15'h0000;
            // top pin is address in byte mode, data otherwise [RL4]
            top_data_or_low_addr_out <= byte_ff ? addr_ff[0] : wdata_ff[15];
            top_data_or_low_addr_oe <= (byte_ff & active) | (active & ~is_read);
        end
    end

    // ************************************************************
    // answer
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
        end else begin
            // ready drops as soon as a request shows, so one request is taken at a time
            req_ready <= (state_ff == fbod_pkg::FBOD_ST_IDLE) & ~req_valid;
            // one pulse per operation, in the cycle after the last recovery cycle
            rsp_valid <= (state_ff == fbod_pkg::FBOD_ST_RECOVER) & cnt_done;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rsp_rdata <= 16'h0000;
        end else if (in_strobe & cnt_done & is_read) begin
            // status and id reads use the same timing, low byte [RL12] [RL13]
            rsp_rdata <= byte_ff ? {8'h00, dq_sync_ff[7:0]} : dq_sync_ff; // [RL1] [RL7] [RL9]
        end
    end
endmodule
`default_nettype wire

// ---- fbod_chk.sv ----
// assertions on the pins of the flash host controller
`timescale 1ns/100ps
`default_nettype none
module fbod_chk (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic flash_cs_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n,
    input wire logic flash_reset_n,
    input wire logic flash_elevated_id_voltage,
    input wire logic flash_byte_n,
    input wire logic [18:0] flash_addr,
    input wire logic [14:0] flash_dq_oe,
    input wire logic top_data_or_low_addr_oe
);
    // ***
    // pin relations
    // ***
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence taken;
        req_valid && req_ready;
    endsequence
    sequence hv_strobe;
        !flash_we_n && flash_elevated_id_voltage;
    endsequence
    chk_read_we_high: assert property (!flash_oe_n |-> flash_we_n && !flash_cs_n)
        else $error("output enable low without select or with write low");
    chk_write_oe_high: assert property (!flash_we_n |-> flash_oe_n && !flash_cs_n)
        else $error("write strobe without select or with output enable low");
    chk_write_hold_sel: assert property ($rose(flash_we_n) |-> !flash_cs_n && flash_reset_n)
        else $error("write strobe ended without select held");
    chk_read_no_drive: assert property (!flash_oe_n |-> flash_dq_oe == 15'h0)
        else $error("host drives data during a read");
    chk_byte_low_addr: assert property (!flash_oe_n && !flash_byte_n |-> top_data_or_low_addr_oe)
        else $error("low address bit not driven in byte read");
    chk_prot_addr_bits: assert property (hv_strobe |-> flash_addr[1] && !flash_addr[0])
        else $error("protect strobe with wrong low address bits");
    chk_reset_quiet: assert property (!flash_reset_n |-> flash_cs_n && flash_oe_n && flash_we_n)
        else $error("bus active during hardware reset");
    chk_reset_pulse_len: assert property ($fell(flash_reset_n) |-> !flash_reset_n [*5])
        else $error("hardware reset pulse too short");
    chk_rsp_one_cycle: assert property (rsp_valid |=> !rsp_valid)
        else $error("response longer than one cycle");
    chk_answer_bound: assert property (taken |-> ##[2:12] rsp_valid)
        else $error("no response in time");
endmodule
`default_nettype wire

// ---- fbod_flash_model.sv ----
// behavioural flash device on the far side of the host
`timescale 1ns/100ps
`default_nettype none
module fbod_flash_model (
    input wire logic cs_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic reset_n,
    input wire logic hv,
    input wire logic byte_n,
    input wire logic [18:0] addr,
    input wire logic [15:0] bus,
    output logic [15:0] q,
    output logic rb
);
    // ***
    // array, read path, write latch
    // ***
    logic [15:0] mem [256];
    logic [15:0] w;
    logic flip = 1'b0;
    int busy = 0;
    // floating pins toggle so a stale value never passes
    always #50 flip = ~flip;
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = {8'h5A ^ 8'(i), 8'(i)};
    end
    always_comb begin
        w = mem[addr[7:0]];
        q = {16{flip}};
        if (!cs_n && !oe_n && we_n && reset_n) begin
            if (byte_n) q = w;
            else q[7:0] = bus[15] ? w[15:8] : w[7:0];
        end
    end
    // plain write stores at once; command sequences left out
    always @(posedge we_n) begin
        if (!cs_n && oe_n && reset_n && !hv) begin
            if (byte_n) mem[addr[7:0]] <= bus;
            else if (bus[15]) mem[addr[7:0]][15:8] <= bus[7:0];
            else mem[addr[7:0]][7:0] <= bus[7:0];
            busy = 30;
        end
    end
    always #100 begin
        if (!reset_n) busy = 0;
        else if (busy > 0) busy = busy - 1;
    end
    assign rb = (busy == 0);
endmodule
`default_nettype wire

// ---- flash_bus_operation_decode_bench.sv ----
// testbench for the flash host controller
`timescale 1ns/100ps
`default_nettype none
module flash_bus_operation_decode_bench;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    fbod_pkg::fbod_op_t req_op = fbod_pkg::FBOD_OP_READ;
    logic req_byte_mode = 1'b0;
    logic [19:0] req_addr = 20'h0;
    logic [15:0] req_wdata = 16'h0;
    logic req_ready, rsp_valid, dev_busy, cs_n, oe_n, we_n, rs_n, hv, byte_n, t_out, t_oe, rb;
    logic [15:0] rsp_rdata, mq;
    logic [18:0] fa;
    logic [14:0] d_out, d_oe;
    logic seen_a6;
    int err_count = 0;
    int checked = 0;
    int cyc = 0;
    int hv_seen = 0;
    wire logic [15:0] bus = {t_oe ? t_out : mq[15], (d_oe & d_out) | (~d_oe & mq[14:0])};
    always #50 core_clk = ~core_clk;
    // access count above the default stretches the read strobe
    fbod_host #(.ACC_CYC(3)) u_dut (.core_clk(core_clk), .rst(rst), .req_valid(req_valid),
        .req_op(req_op), .req_byte_mode(req_byte_mode), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .dev_busy(dev_busy), .flash_cs_n(cs_n), .flash_oe_n(oe_n),
        .flash_we_n(we_n), .flash_reset_n(rs_n), .flash_elevated_id_voltage(hv),
        .flash_byte_n(byte_n), .flash_addr(fa), .flash_dq_out(d_out), .flash_dq_oe(d_oe),
        .top_data_or_low_addr_out(t_out), .top_data_or_low_addr_oe(t_oe),
        .flash_dq_in(bus[14:0]), .top_data_or_low_addr_in(bus[15]), .ready_busy_out(rb));
    fbod_flash_model u_mem (.cs_n(cs_n), .oe_n(oe_n), .we_n(we_n), .reset_n(rs_n), .hv(hv),
        .byte_n(byte_n), .addr(fa), .bus(bus), .q(mq), .rb(rb));
    always @(posedge core_clk) begin
        if (!we_n && hv) begin
            seen_a6 <= fa[6];
            hv_seen <= hv_seen + 1;
        end
    end
    function automatic logic [15:0] init_word(input logic [7:0] i);
        return {8'h5A ^ i, i};
    endfunction
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic op(input fbod_pkg::fbod_op_t o, input logic b, input logic [19:0] a,
        input logic [15:0] d);
        @(negedge core_clk);
        while (req_ready !== 1'b1) @(negedge core_clk);
        req_op = o;
        req_byte_mode = b;
        req_addr = a;
        req_wdata = d;
        req_valid = 1'b1;
        @(negedge core_clk);
        req_valid = 1'b0;
        while (rsp_valid !== 1'b1) @(negedge core_clk);
    endtask
    task automatic t_boot();
        op(fbod_pkg::FBOD_OP_READ, 1'b0, 20'h00024, 16'h0);
        check("boot read", rsp_rdata, init_word(8'h12));
    endtask
    task automatic t_write();
        op(fbod_pkg::FBOD_OP_WRITE, 1'b0, 20'h00068, 16'hBEEF);
        repeat (4) @(negedge core_clk);
        check("busy after write", {15'h0, dev_busy}, 16'h1);
        repeat (40) @(negedge core_clk);
        check("busy over", {15'h0, dev_busy}, 16'h0);
        op(fbod_pkg::FBOD_OP_READ, 1'b0, 20'h00068, 16'h0);
        check("word readback", rsp_rdata, 16'hBEEF);
    endtask
    task automatic t_byte();
        op(fbod_pkg::FBOD_OP_READ, 1'b1, 20'h00069, 16'h0);
        check("byte read high", rsp_rdata, 16'h00BE);
        op(fbod_pkg::FBOD_OP_WRITE, 1'b1, 20'h00068, 16'h0077);
        repeat (40) @(negedge core_clk);
        op(fbod_pkg::FBOD_OP_READ, 1'b0, 20'h00068, 16'h0);
        check("byte write lane", rsp_rdata, 16'hBE77);
    endtask
    task automatic t_reset();
        op(fbod_pkg::FBOD_OP_WRITE, 1'b0, 20'h000AC, 16'h1234);
        op(fbod_pkg::FBOD_OP_RESET, 1'b0, 20'h0, 16'h0);
        repeat (4) @(negedge core_clk);
        check("busy aborted", {15'h0, dev_busy}, 16'h0);
        op(fbod_pkg::FBOD_OP_READ, 1'b0, 20'h00040, 16'h0);
        check("read after reset", rsp_rdata, init_word(8'h20));
        op(fbod_pkg::fbod_op_t'(3'h7), 1'b0, 20'h00042, 16'hFFFF);
        check("unknown op reads", rsp_rdata, init_word(8'h21));
    endtask
    task automatic t_prot();
        int n;
        for (int k = 0; k < 2; k++) begin
            n = hv_seen;
            op(k ? fbod_pkg::FBOD_OP_UNPROTECT : fbod_pkg::FBOD_OP_PROTECT, 1'b0, 20'h0, 16'h0);
            check("protect strobes", 16'(hv_seen - n), 16'h0001);
            check("protect a6", {15'h0, seen_a6}, 16'(k));
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // generous ceiling; a full pass needs under two hundred cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            conclude();
        end
    end
    initial begin
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        t_boot();
        t_write();
        t_byte();
        t_reset();
        t_prot();
        conclude();
    end
endmodule
bind fbod_host fbod_chk u_chk (.core_clk, .rst, .req_valid, .req_ready, .rsp_valid,
    .flash_cs_n, .flash_oe_n, .flash_we_n, .flash_reset_n, .flash_elevated_id_voltage,
    .flash_byte_n, .flash_addr, .flash_dq_oe, .top_data_or_low_addr_oe);
`default_nettype wire
